// ===== timebase_defines.svh
// register offsets, field positions, reset values and counts for the counter array
`ifndef TIMEBASE_DEFINES_SVH
`define TIMEBASE_DEFINES_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define REG_COUNT_LOW 8'h00
`define REG_COUNT_HIGH 8'h04
`define REG_MODE 8'h08
`define REG_STATUS 8'h0C
`define REG_MASK 8'h10
`define REG_ROUTE 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define MODE_TB_LSB 1
`define MODE_TB_MSB 3
`define MODE_WDT_BIT 6
`define MODE_IDLE_BIT 7
`define STAT_OVF_BIT 0
`define BYTE_MSB 7
`define ROUTE_MSB 2

// ****************************************************************
// reset values and constants
// ****************************************************************
`define MODE_RST 8'h40
`define COUNT_RST 16'h0000
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`define BYTE_ZERO 8'h00
`define ROUTE_RST 3'h0
`define ZERO24 24'h00_0000
`define ZERO32 32'h0000_0000
`define ZERO29 29'h0000_0000
`define ZERO31 31'h0000_0000

// ****************************************************************
// prescaler ratios
// ****************************************************************
`define DIV_SLOW 12
`define DIV_FAST 4

`endif

// ===== timebase_pkg.sv
// types shared by the counter array timebase
package timebase_pkg;

   // ****************************************************************
   // timebase select codes
   // ****************************************************************
   typedef enum logic [2:0] {
      TB_DIV12 = 3'h0,
      TB_DIV4 = 3'h1,
      TB_TMR0 = 3'h2,
      TB_EXT_FALL = 3'h3,
      TB_SYSCLK = 3'h4,
      TB_XOSC8 = 3'h5,
      TB_RTC8 = 3'h6,
      TB_RSVD = 3'h7
   } timebase_t;

   // ****************************************************************
   // mode register fields
   // ****************************************************************
   typedef struct packed {
      logic idle_halt_select;
      logic module_two_watchdog;
      logic spare;
      logic spare2;
      timebase_t timebase_select;
      logic spare3;
   } mode_t;

   // ****************************************************************
   // one synchronised input, with its edges
   // ****************************************************************
   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } edge_t;

endpackage : timebase_pkg

// ===== tick_divider.sv
// fixed-ratio prescaler giving one-cycle ticks
`timescale 1ns/100ps
module tick_divider #(
   parameter int DIV = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   localparam logic [3:0] LAST = 4'(DIV - 1);
   logic [3:0] cnt_r;

   // free running so a source switch lands on a steady phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
      end else if (cnt_r == LAST) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   assign tick = (cnt_r == LAST);

endmodule : tick_divider

// ===== sync_edge.sv
// two-flop synchroniser with edge detection
`timescale 1ns/100ps
module sync_edge
   import timebase_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic din,
   output edge_t sig
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // s1 feeds s2 only; edges come from s2 against s3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign sig.level = s2_r;
   assign sig.rise = s2_r & ~s3_r;
   assign sig.fall = s3_r & ~s2_r;

endmodule : sync_edge

// ===== counter_array_timebase.sv
// 16-bit counter array timebase with apb registers
//
// Function
// - 16-bit count as two byte registers
// - low read snapshots high; high read returns it
// - count reads never disturb counting
// - wrap from max to zero sets flag
// - irq when flag set and enabled
// - flag stays until software clears it
// - idle halt bit zero keeps counting in idle
// - codes pick div12, div4, timer0, sysclk
// - code 3 counts external falling edges
// - code 5 counts synced oscillator/8 edges
// - code 6 counts synced rtc/8 edges
// - count shared; module lines routed when enabled
// - watchdog on after reset, locks mode writes except to the watchdog bit itself
`include "timebase_defines.svh"
`timescale 1ns/100ps
module counter_array_timebase
   import timebase_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic ext_count_input,
   input wire logic ext_osc_div8,
   input wire logic rtc_osc_div8,
   input wire logic [2:0] module_io_out,
   input wire logic [2:0] module_io_drive,
   output logic [2:0] module_io_pin_o,
   output logic [2:0] module_io_pin_oe_n,
   output logic [15:0] count_value,
   output logic module_two_watchdog,
   output logic irq
);

   // ****************************************************************
   // state
   // ****************************************************************
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [7:0] snap_r;
   mode_t mode_r;
   mode_t mode_nxt;
   logic ovf_flag_r;
   logic ovf_flag_nxt;
   logic ovf_mask_r;
   logic [2:0] route_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic [2:0] pin_o_r;
   logic [2:0] pin_oe_n_r;
   logic setup;
   logic wr;
   logic tick_slow;
   logic tick_fast;
   logic tick_sel;
   logic halt;
   logic inc;
   logic ovf_evt;
   logic flag_clr;
   edge_t ext_e;
   edge_t xosc_e;
   edge_t rtc_e;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   // zero wait states: read data are latched in the setup cycle
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `ZERO32;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         pslverr_r <= 1'b0;
         case (paddr)
            `REG_COUNT_LOW: prdata_r <= {`ZERO24, count_r[7:0]};
            `REG_COUNT_HIGH: prdata_r <= {`ZERO24, snap_r};
            `REG_MODE: prdata_r <= {`ZERO24, mode_r};
            `REG_STATUS: prdata_r <= {`ZERO31, ovf_flag_r};
            `REG_MASK: prdata_r <= {`ZERO31, ovf_mask_r};
            `REG_ROUTE: prdata_r <= {`ZERO29, route_r};
            default: begin
               prdata_r <= `ZERO32;
               pslverr_r <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************************************
   // snapshot of the high byte
   // ****************************************************************
   // taken in the same cycle as the low byte, so the pair is coherent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_r <= `BYTE_ZERO;
      end else if (setup && !pwrite && paddr == `REG_COUNT_LOW) begin
         snap_r <= count_r[15:8];
      end
   end

   // ****************************************************************
   // timebase sources
   // ****************************************************************
   tick_divider #(.DIV(`DIV_SLOW)) u_div_slow (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_slow)
   );

   tick_divider #(.DIV(`DIV_FAST)) u_div_fast (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_fast)
   );

   // external pin edges faster than sysclk/4 may merge
   sync_edge u_ext (
      .pclk(pclk),
      .presetn(presetn),
      .din(ext_count_input),
      .sig(ext_e)
   );

   sync_edge u_xosc (
      .pclk(pclk),
      .presetn(presetn),
      .din(ext_osc_div8),
      .sig(xosc_e)
   );

   sync_edge u_rtc (
      .pclk(pclk),
      .presetn(presetn),
      .din(rtc_osc_div8),
      .sig(rtc_e)
   );

   always_comb begin
      case (mode_r.timebase_select)
         TB_DIV12: tick_sel = tick_slow;
         TB_DIV4: tick_sel = tick_fast;
         TB_TMR0: tick_sel = timer0_overflow;
         TB_EXT_FALL: tick_sel = ext_e.fall;
         TB_SYSCLK: tick_sel = 1'b1;
         TB_XOSC8: tick_sel = xosc_e.rise;
         TB_RTC8: tick_sel = rtc_e.rise;
         TB_RSVD: tick_sel = 1'b0;
         default: tick_sel = 1'b0;
      endcase
   end

   // idle only stops the count when software asked for it
   assign halt = cpu_idle & mode_r.idle_halt_select;
   assign inc = tick_sel & ~halt;

   // ****************************************************************
   // counter
   // ****************************************************************
   always_comb begin
      count_nxt = count_r;
      ovf_evt = 1'b0;
      if (wr && paddr == `REG_COUNT_LOW) begin
         count_nxt[7:0] = pwdata[`BYTE_MSB:0];
      end else if (wr && paddr == `REG_COUNT_HIGH) begin
         count_nxt[15:8] = pwdata[`BYTE_MSB:0];
      end else if (inc) begin
         // reads still reach here: only writes override counting
         count_nxt = count_r + `COUNT_ONE;
         ovf_evt = (count_r == `COUNT_MAX);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= `COUNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count_value = count_r;

   // ****************************************************************
   // mode register and watchdog lock
   // ****************************************************************
   always_comb begin
      mode_nxt = mode_r;
      if (wr && paddr == `REG_MODE) begin
         if (mode_r.module_two_watchdog) begin
            // locked: only the watchdog bit itself may change
            mode_nxt.module_two_watchdog = pwdata[`MODE_WDT_BIT];
         end else begin
            mode_nxt = mode_t'(pwdata[`BYTE_MSB:0]);
         end
      end
      mode_nxt.spare = 1'b0;
      mode_nxt.spare2 = 1'b0;
      mode_nxt.spare3 = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= mode_t'(`MODE_RST);
      end else begin
         mode_r <= mode_nxt;
      end
   end

   assign module_two_watchdog = mode_r.module_two_watchdog;

   // ****************************************************************
   // overflow flag, mask and interrupt
   // ****************************************************************
   assign flag_clr = wr && paddr == `REG_STATUS && pwdata[`STAT_OVF_BIT];
   // a wrap in the clearing cycle wins over the clear
   assign ovf_flag_nxt = (ovf_flag_r & ~flag_clr) | ovf_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag_r <= 1'b0;
      end else begin
         ovf_flag_r <= ovf_flag_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_mask_r <= 1'b0;
      end else if (wr && paddr == `REG_MASK) begin
         ovf_mask_r <= pwdata[`STAT_OVF_BIT];
      end
   end

   // no hardware acknowledge path: servicing leaves the flag set
   assign irq = ovf_flag_r & ovf_mask_r;

   // ****************************************************************
   // module line routing
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_r <= `ROUTE_RST;
      end else if (wr && paddr == `REG_ROUTE) begin
         route_r <= pwdata[`ROUTE_MSB:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o_r <= 3'h0;
         pin_oe_n_r <= 3'h7;
      end else begin
         pin_o_r <= module_io_out;
         pin_oe_n_r <= ~(route_r & module_io_drive);
      end
   end

   assign module_io_pin_o = pin_o_r;
   assign module_io_pin_oe_n = pin_oe_n_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_low_read;
      setup && !pwrite && paddr == `REG_COUNT_LOW;
   endsequence

   sequence s_high_read;
      setup && !pwrite && paddr == `REG_COUNT_HIGH;
   endsequence

   a_snap_take: assert property (@(posedge pclk) disable iff (!presetn)
      s_low_read |=> snap_r == $past(count_r[15:8]))
      else $error("low byte read did not snapshot high byte");

   a_snap_return: assert property (@(posedge pclk) disable iff (!presetn)
      s_high_read |=> prdata_r[`BYTE_MSB:0] == $past(snap_r))
      else $error("high byte read not from snapshot");

   a_read_still: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !pwrite && !inc) |=> count_r == $past(count_r))
      else $error("read disturbed the count");

   a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (inc && !wr && count_r == `COUNT_MAX)
      |=> ovf_flag_r && count_r == `COUNT_RST)
      else $error("wrap did not set overflow flag");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (ovf_flag_r && ovf_mask_r))
      else $error("irq does not follow flag and enable");

   a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf_flag_r && !flag_clr) |=> ovf_flag_r)
      else $error("overflow flag cleared without software");

   a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (cpu_idle && mode_r.idle_halt_select && !wr) |=> count_r == $past(count_r))
      else $error("count moved while halted in idle");

   a_slow_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick_slow |-> ##12 tick_slow)
      else $error("slow prescaler period wrong");

   a_fast_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick_fast |=> !tick_fast [*3] ##1 tick_fast)
      else $error("fast prescaler period wrong");

   a_ext_once: assert property (@(posedge pclk) disable iff (!presetn)
      ext_e.fall |=> !ext_e.fall)
      else $error("one external edge counted twice");

   a_ext_count: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_r.timebase_select == TB_EXT_FALL && !wr && !halt)
      |-> (inc == ext_e.fall))
      else $error("external edge mode miscounts");

   a_reserved_off: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_r.timebase_select == TB_RSVD && !wr) |=> $stable(count_r))
      else $error("reserved timebase incremented");

   a_wdt_lock: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_r.module_two_watchdog) |=> $stable(mode_r.timebase_select))
      else $error("mode changed while watchdog locked");

   a_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
      (!route_r[0]) |=> module_io_pin_oe_n[0])
      else $error("unrouted module line driven");

endmodule : counter_array_timebase

// ===== far_side_sources.sv
// far-side model: timer 0 pulses, count pin and divided oscillators
`timescale 1ns/100ps
module far_side_sources (
   input wire logic pclk,
   input wire logic presetn,
   output logic timer0_overflow,
   output logic ext_count_input,
   output logic ext_osc_div8,
   output logic rtc_osc_div8
);
   logic [2:0] t0_cnt_r;
   logic [1:0] pin_cnt_r;

   // ****************************************************************
   // synchronous sources
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_cnt_r <= 3'h0;
         timer0_overflow <= 1'b0;
      end else begin
         t0_cnt_r <= (t0_cnt_r == 3'h4) ? 3'h0 : t0_cnt_r + 3'h1;
         timer0_overflow <= (t0_cnt_r == 3'h4);
      end
   end

   // pin period of 8 clocks, slower than the sysclk/4 limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_cnt_r <= 2'h0;
         ext_count_input <= 1'b1;
      end else begin
         pin_cnt_r <= pin_cnt_r + 2'h1;
         if (pin_cnt_r == 2'h3) begin
            ext_count_input <= ~ext_count_input;
         end
      end
   end

   // ****************************************************************
   // free-running oscillators, phase unrelated to pclk
   // ****************************************************************
   initial begin
      ext_osc_div8 = 1'b0;
      #13;
      forever #200 ext_osc_div8 = ~ext_osc_div8;
   end

   initial begin
      rtc_osc_div8 = 1'b0;
      #7;
      forever #480 rtc_osc_div8 = ~rtc_osc_div8;
   end
endmodule : far_side_sources

// ===== tb_top.sv
// self-checking bench for the counter array timebase
`include "timebase_defines.svh"
`timescale 1ns/100ps
module tb_top
   import timebase_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cpu_idle = 1'b0;
   logic timer0_overflow, ext_count_input, ext_osc_div8, rtc_osc_div8;
   logic [2:0] module_io_out = 3'h0;
   logic [2:0] module_io_drive = 3'h0;
   logic [2:0] module_io_pin_o, module_io_pin_oe_n;
   logic [15:0] count_value;
   logic module_two_watchdog;
   logic irq;
   logic [31:0] rd;
   logic err;
   logic [15:0] c_a;
   int num_errors = 0;
   int n_tests = 0;
   // ticks per 120-clock window for codes 0..7
   int exp_rate [8] = '{10, 30, 24, 15, 120, 12, 5, 0};

   always #20 pclk = ~pclk;

   counter_array_timebase DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
      .timer0_overflow(timer0_overflow), .ext_count_input(ext_count_input),
      .ext_osc_div8(ext_osc_div8), .rtc_osc_div8(rtc_osc_div8),
      .module_io_out(module_io_out), .module_io_drive(module_io_drive),
      .module_io_pin_o(module_io_pin_o), .module_io_pin_oe_n(module_io_pin_oe_n),
      .count_value(count_value), .module_two_watchdog(module_two_watchdog), .irq(irq));

   far_side_sources src (.pclk(pclk), .presetn(presetn),
      .timer0_overflow(timer0_overflow), .ext_count_input(ext_count_input),
      .ext_osc_div8(ext_osc_div8), .rtc_osc_div8(rtc_osc_div8));

   // ****************************************************************
   // bus and check tasks
   // ****************************************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench watchdog ends a stalled access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // counts ticks seen in a 120-clock window
   task automatic rate(input string name, input int exp);
      @(posedge pclk);
      c_a = count_value;
      cyc(120);
      chk(name, exp, {16'h0000, count_value - c_a});
   endtask : rate

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #400_000;
      num_errors++;
      tally_and_finish();
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      cyc(6);
      presetn <= 1'b1;
      cyc(2);
      chk("wdog_port", 1, module_two_watchdog);
      apb(0, `REG_MODE, 0);
      chk("mode_rst", 32'h0000_0040, rd);
      chk("pready", 1, pready);
      // watchdog bit kept set, so the timebase field must not move
      apb(1, `REG_MODE, 32'h0000_004E);
      apb(0, `REG_MODE, 0);
      chk("mode_locked", 32'h0000_0040, rd);
      apb(1, `REG_MODE, 0);
      cyc(1);
      chk("wdog_off", 0, module_two_watchdog);
      apb(1, `REG_MODE, 32'h0000_000E);
      apb(0, `REG_COUNT_HIGH, 0);
      chk("snap_rst", 0, rd);
      apb(1, `REG_COUNT_LOW, 32'h0000_00FE);
      apb(1, `REG_COUNT_HIGH, 32'h0000_00FF);
      cyc(20);
      chk("frozen", 32'h0000_FFFE, {16'h0000, count_value});
      // low first, then high, for a coherent pair
      apb(0, `REG_COUNT_LOW, 0);
      chk("low", 32'h0000_00FE, rd);
      apb(1, `REG_COUNT_HIGH, 32'h0000_0012);
      apb(0, `REG_COUNT_HIGH, 0);
      chk("snap", 32'h0000_00FF, rd);
      chk("undisturbed", 32'h0000_12FE, {16'h0000, count_value});
      apb(1, `REG_COUNT_HIGH, 32'h0000_00FF);
      apb(1, `REG_STATUS, 32'h0000_0001);
      apb(1, `REG_MASK, 32'h0000_0001);
      chk("irq_idle", 0, irq);
      apb(1, `REG_MODE, 32'h0000_0008);
      apb(1, `REG_MODE, 32'h0000_000E);
      cyc(2);
      chk("ovf_irq", 1, irq);
      apb(0, `REG_STATUS, 0);
      chk("ovf_flag", 1, rd[0]);
      cyc(30);
      chk("flag_sticky", 1, irq);
      apb(1, `REG_MASK, 0);
      cyc(1);
      chk("irq_masked", 0, irq);
      apb(1, `REG_MASK, 32'h0000_0001);
      cyc(1);
      chk("irq_unmask", 1, irq);
      apb(1, `REG_STATUS, 32'h0000_0001);
      cyc(1);
      chk("irq_clr", 0, irq);
      apb(0, `REG_STATUS, 0);
      chk("flag_clr", 0, rd[0]);
      for (int c = 0; c < 8; c++) begin
         apb(1, `REG_MODE, {28'h000_0000, c[2:0], 1'b0});
         cyc(8);
         rate("tb_rate", exp_rate[c]);
      end
      cpu_idle <= 1'b1;
      apb(1, `REG_MODE, 32'h0000_0008);
      rate("idle_run", 120);
      apb(1, `REG_MODE, 32'h0000_0088);
      rate("idle_halt", 0);
      cpu_idle <= 1'b0;
      rate("idle_off", 120);
      apb(0, 8'h20, 0);
      chk("unmapped_err", 1, err);
      chk("unmapped_rd", 0, rd);
      module_io_out <= 3'b101;
      module_io_drive <= 3'b111;
      cyc(3);
      chk("oe_off", 32'h0000_0007, {29'h0000_0000, module_io_pin_oe_n});
      apb(1, `REG_ROUTE, 32'h0000_0005);
      cyc(3);
      chk("oe_route", 32'h0000_0002, {29'h0000_0000, module_io_pin_oe_n});
      chk("pin_out", 32'h0000_0005, {29'h0000_0000, module_io_pin_o});
      tally_and_finish();
   end
endmodule : tb_top
